/* rtl/vxeg_defs.svh */
// constants of the virtualization enable gate: offsets, field positions, codes
// assumes inclusion by every file of the block except the package, with a byte-addressed register port
`ifndef VXEG_DEFS_SVH
`define VXEG_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define VXEG_REG_CTRL 8'h00
`define VXEG_REG_CAP 8'h04
`define VXEG_REG_STAT 8'h08
`define VXEG_REG_MASK 8'h0C
`define VXEG_REG_MODE 8'h10

// ----------------------------------------
// control register fields
// ----------------------------------------
`define VXEG_CTRL_ENABLE 0
`define VXEG_CTRL_DISABLE 1
`define VXEG_CTRL_LOCK 2

// ----------------------------------------
// capability fields, also used in the identification words
// ----------------------------------------
`define VXEG_CAP_AVAIL 2
`define VXEG_CAP_SECINIT 12
`define VXEG_CAP_LOCKCAP 2
`define VXEG_HV_PRESENT 31

// ----------------------------------------
// status and mask fields
// ----------------------------------------
`define VXEG_EV_UD 0
`define VXEG_EV_GP 1
`define VXEG_EV_EXIT 2
`define VXEG_EV_DMA 3
`define VXEG_EV_W 4

// ----------------------------------------
// identification leaves and misc values
// ----------------------------------------
`define VXEG_LEAF_BASIC 32'h0000_0001
`define VXEG_LEAF_EXT 32'h8000_0001
`define VXEG_LEAF_VIRT 32'h8000_000A
`define VXEG_LEAF_HV_LO 32'h4000_0000
`define VXEG_LEAF_HV_HI 32'h4000_00FF
`define VXEG_HV_OWNER 4'h0
`define VXEG_GP_CODE 16'h0000
`define VXEG_RESET_WORD 32'h0000_0000

`endif

/* rtl/vxeg_pkg.sv */
// types of the virtualization enable gate
// assumes the defs header is compiled with it
package vxeg_pkg;

  typedef enum logic [3:0] {
    VXEG_OP_NONE,
    VXEG_OP_GUEST_ENTER,
    VXEG_OP_STATE_LOAD,
    VXEG_OP_STATE_SAVE,
    VXEG_OP_GI_CLEAR,
    VXEG_OP_GI_SET,
    VXEG_OP_HV_CALL,
    VXEG_OP_PAGE_INV,
    VXEG_OP_SECURE_INIT
  } vxeg_op_t;

  typedef enum logic [1:0] {
    VXEG_SEL_BASIC,
    VXEG_SEL_EXT,
    VXEG_SEL_VIRT,
    VXEG_SEL_ZERO
  } vxeg_sel_t;

endpackage

/* rtl/vxeg_cpuid_rom.sv */
// identification word table for the enable gate
// assumes a selector from the same clock; data appear one cycle after rdEn
`timescale 1ns/1ps
`include "vxeg_defs.svh"

module vxeg_cpuid_rom #(
  parameter logic AVAIL_CAP = 1'b1,
  parameter logic SECINIT_CAP = 1'b1,
  parameter logic LOCK_CAP = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rdEn,
  input wire vxeg_pkg::vxeg_sel_t sel,
  output logic [31:0] data_r
);

  logic [31:0] data_nxt;

  always_comb begin
    data_nxt = data_r;
    if (rdEn) begin
      data_nxt = `VXEG_RESET_WORD;
      unique case (sel)
        vxeg_pkg::VXEG_SEL_BASIC: begin
          // physical part: hypervisor-present bit always reads zero
          data_nxt[`VXEG_HV_PRESENT] = 1'b0; // see (RULE6)
        end
        vxeg_pkg::VXEG_SEL_EXT: begin
          data_nxt[`VXEG_CAP_AVAIL] = AVAIL_CAP;
          data_nxt[`VXEG_CAP_SECINIT] = SECINIT_CAP;
        end
        vxeg_pkg::VXEG_SEL_VIRT: begin
          data_nxt[`VXEG_CAP_LOCKCAP] = LOCK_CAP;
        end
        vxeg_pkg::VXEG_SEL_ZERO: begin
          data_nxt = `VXEG_RESET_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      data_r <= `VXEG_RESET_WORD;
    end else begin
      data_r <= data_nxt;
    end
  end

endmodule

/* rtl/vxeg_gate.sv */
// decode-time gate and capability report of the virtualization extension
// assumes all inputs come from core logic on mclk; register port is one-cycle read
//
// Functional notes
// (RULE1) virt instructions need enable bit, else invalid-opcode
// (RULE2) secure-init, gi-set need enable or secure-init flag
// (RULE3) software checks availability flag first
// (RULE4) software: disable bit zero means enabling allowed
// (RULE5) software: lock-capable flag tells unlockability
// (RULE6) hypervisor-present identification bit reads zero
// (RULE7) hypervisor leaf range left undefined, returns zero
// (RULE8) guest mode only via guest-enter, instructions intercepted
// (RULE9) physical interrupt exits guest when requested
// (RULE10) guest mask flag, priority use virtual copies
// (RULE11) intercepted instructions restartable except task switches
// (RULE12) device DMA blocked from foreign owner memory
// (RULE13) guest-enter: invalid-opcode, then protection fault code zero
// (RULE14) enable bit sampled per instruction at decode
`timescale 1ns/1ps
`include "vxeg_defs.svh"

module vxeg_gate #(
  parameter logic AVAIL_CAP = 1'b1,
  parameter logic SECINIT_CAP = 1'b1,
  parameter logic LOCK_CAP = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  output logic [31:0] busRdata,
  output logic irq,
  input wire logic instrValid,
  input wire vxeg_pkg::vxeg_op_t instrOp,
  input wire logic [1:0] curPriv,
  input wire logic protMode,
  input wire logic guestIntercept,
  input wire logic interceptTaskSwitch,
  input wire logic guestExit,
  input wire logic intrExitEn,
  input wire logic physIntrPend,
  input wire logic virtIntrEn,
  input wire logic physIf,
  input wire logic virtIf,
  input wire logic [3:0] physTpr,
  input wire logic [3:0] virtTpr,
  input wire logic dmaValid,
  input wire logic [3:0] dmaDevGuest,
  input wire logic [3:0] dmaPageOwner,
  input wire logic cpuidValid,
  input wire logic [31:0] cpuidLeaf,
  output logic decValid,
  output logic execOk,
  output logic udFault,
  output logic gpFault,
  output logic [15:0] gpErrCode,
  output logic inGuest,
  output logic vmExit,
  output logic restartOk,
  output logic effIf,
  output logic [3:0] effTpr,
  output logic dmaBlock,
  output logic cpuidDone,
  output logic cpuidReserved,
  output logic [31:0] cpuidData
);

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic needsEnable(input vxeg_pkg::vxeg_op_t op);
    needsEnable = (op == vxeg_pkg::VXEG_OP_GUEST_ENTER) || (op == vxeg_pkg::VXEG_OP_STATE_LOAD) ||
                  (op == vxeg_pkg::VXEG_OP_STATE_SAVE) || (op == vxeg_pkg::VXEG_OP_GI_CLEAR) ||
                  (op == vxeg_pkg::VXEG_OP_HV_CALL) || (op == vxeg_pkg::VXEG_OP_PAGE_INV);
  endfunction

  function automatic logic enableOrSecinit(input vxeg_pkg::vxeg_op_t op);
    enableOrSecinit = (op == vxeg_pkg::VXEG_OP_SECURE_INIT) || (op == vxeg_pkg::VXEG_OP_GI_SET);
  endfunction

  // ----------------------------------------
  // control and status registers
  // ----------------------------------------
  logic enable_r, enable_nxt;
  logic disable_r, disable_nxt;
  logic lock_r, lock_nxt;
  logic [`VXEG_EV_W-1:0] stat_r, stat_nxt;
  logic [`VXEG_EV_W-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [`VXEG_EV_W-1:0] events;
  logic inGuest_r;

  always_comb begin
    enable_nxt = enable_r;
    disable_nxt = disable_r;
    lock_nxt = lock_r;
    mask_nxt = mask_r;
    rdata_nxt = `VXEG_RESET_WORD;
    stat_nxt = stat_r;
    if (busWr) begin
      unique case (busAddr)
        `VXEG_REG_CTRL: begin
          // the disable bit is frozen once locked; lock holds until reset
          if (!lock_r) begin
            disable_nxt = busWdata[`VXEG_CTRL_DISABLE];
          end
          lock_nxt = lock_r | busWdata[`VXEG_CTRL_LOCK];
          enable_nxt = busWdata[`VXEG_CTRL_ENABLE] & ~disable_nxt & AVAIL_CAP;
        end
        `VXEG_REG_STAT: stat_nxt = stat_r & ~busWdata[`VXEG_EV_W-1:0];
        `VXEG_REG_MASK: mask_nxt = busWdata[`VXEG_EV_W-1:0];
        default: begin
        end
      endcase
    end
    // set wins over a write-one clear in the same cycle
    stat_nxt = stat_nxt | events;
    if (busRd) begin
      unique case (busAddr)
        `VXEG_REG_CTRL: begin
          rdata_nxt[`VXEG_CTRL_ENABLE] = enable_r;
          rdata_nxt[`VXEG_CTRL_DISABLE] = disable_r;
          rdata_nxt[`VXEG_CTRL_LOCK] = lock_r;
        end
        `VXEG_REG_CAP: begin
          rdata_nxt[`VXEG_CAP_AVAIL] = AVAIL_CAP;
          rdata_nxt[`VXEG_CAP_SECINIT] = SECINIT_CAP;
          rdata_nxt[`VXEG_CAP_LOCKCAP + 1] = LOCK_CAP;
        end
        `VXEG_REG_STAT: rdata_nxt[`VXEG_EV_W-1:0] = stat_r;
        `VXEG_REG_MASK: rdata_nxt[`VXEG_EV_W-1:0] = mask_r;
        `VXEG_REG_MODE: rdata_nxt[0] = inGuest_r;
        default: rdata_nxt = `VXEG_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      enable_r <= 1'b0;
      disable_r <= 1'b0;
      lock_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
      rdata_r <= `VXEG_RESET_WORD;
    end else begin
      enable_r <= enable_nxt;
      disable_r <= disable_nxt;
      lock_r <= lock_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign busRdata = rdata_r;
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------
  // instruction gate and guest mode
  // ----------------------------------------
  logic dec_r, ok_r, ud_r, gp_r, exit_r, restart_r, if_r;
  logic dec_nxt, ok_nxt, ud_nxt, gp_nxt, inGuest_nxt, exit_nxt, restart_nxt, if_nxt;
  logic [3:0] tpr_r, tpr_nxt;
  logic isVirt;

  assign isVirt = needsEnable(instrOp) | enableOrSecinit(instrOp);

  always_comb begin
    dec_nxt = instrValid;
    ok_nxt = 1'b0;
    ud_nxt = 1'b0;
    gp_nxt = 1'b0;
    exit_nxt = 1'b0;
    restart_nxt = restart_r;
    inGuest_nxt = inGuest_r;
    if (instrValid) begin
      // the live enable bit is used, so a write lands on the next instruction
      if (needsEnable(instrOp) && !enable_r) begin
        ud_nxt = 1'b1; // see (RULE1) see (RULE14)
      end else if (enableOrSecinit(instrOp) && !enable_r && !SECINIT_CAP) begin
        ud_nxt = 1'b1; // see (RULE2)
      end else if (instrOp == vxeg_pkg::VXEG_OP_GUEST_ENTER && !protMode) begin
        ud_nxt = 1'b1; // see (RULE13)
      end else if (instrOp == vxeg_pkg::VXEG_OP_GUEST_ENTER && curPriv != 2'b00) begin
        gp_nxt = 1'b1; // see (RULE13)
      end else if (inGuest_r && isVirt && guestIntercept) begin
        exit_nxt = 1'b1; // see (RULE8)
        restart_nxt = 1'b1; // see (RULE11)
      end else begin
        ok_nxt = 1'b1;
        if (instrOp == vxeg_pkg::VXEG_OP_GUEST_ENTER) begin
          inGuest_nxt = 1'b1; // see (RULE8)
        end
      end
    end
    if (inGuest_r && physIntrPend && intrExitEn) begin
      exit_nxt = 1'b1; // see (RULE9)
      restart_nxt = 1'b1;
    end
    // task switches cannot be replayed after the intercept
    if (inGuest_r && interceptTaskSwitch) begin
      exit_nxt = 1'b1;
      restart_nxt = 1'b0; // see (RULE11)
    end
    if (exit_nxt || guestExit) begin
      inGuest_nxt = 1'b0;
    end
    // guest reads see the virtual copies when the host asks for it
    if_nxt = (inGuest_r && virtIntrEn) ? virtIf : physIf; // see (RULE10)
    tpr_nxt = (inGuest_r && virtIntrEn) ? virtTpr : physTpr; // see (RULE10)
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dec_r <= 1'b0;
      ok_r <= 1'b0;
      ud_r <= 1'b0;
      gp_r <= 1'b0;
      exit_r <= 1'b0;
      restart_r <= 1'b0;
      inGuest_r <= 1'b0;
      if_r <= 1'b0;
      tpr_r <= 4'h0;
    end else begin
      dec_r <= dec_nxt;
      ok_r <= ok_nxt;
      ud_r <= ud_nxt;
      gp_r <= gp_nxt;
      exit_r <= exit_nxt;
      restart_r <= restart_nxt;
      inGuest_r <= inGuest_nxt;
      if_r <= if_nxt;
      tpr_r <= tpr_nxt;
    end
  end

  assign decValid = dec_r;
  assign execOk = ok_r;
  assign udFault = ud_r;
  assign gpFault = gp_r;
  assign gpErrCode = `VXEG_GP_CODE;
  assign inGuest = inGuest_r;
  assign vmExit = exit_r;
  assign restartOk = restart_r;
  assign effIf = if_r;
  assign effTpr = tpr_r;

  // ----------------------------------------
  // device memory protection and identification
  // ----------------------------------------
  logic dma_r, dma_nxt, cdone_r, cdone_nxt, crsv_r, crsv_nxt;
  vxeg_pkg::vxeg_sel_t romSel;

  always_comb begin
    // hypervisor-owned pages are never open to a device
    dma_nxt = dmaValid && (dmaPageOwner != dmaDevGuest || dmaPageOwner == `VXEG_HV_OWNER);
    cdone_nxt = cpuidValid;
    crsv_nxt = cpuidValid && cpuidLeaf >= `VXEG_LEAF_HV_LO && cpuidLeaf <= `VXEG_LEAF_HV_HI;
    if (crsv_nxt) begin
      romSel = vxeg_pkg::VXEG_SEL_ZERO; // see (RULE7)
    end else if (cpuidLeaf == `VXEG_LEAF_BASIC) begin
      romSel = vxeg_pkg::VXEG_SEL_BASIC;
    end else if (cpuidLeaf == `VXEG_LEAF_EXT) begin
      romSel = vxeg_pkg::VXEG_SEL_EXT;
    end else if (cpuidLeaf == `VXEG_LEAF_VIRT) begin
      romSel = vxeg_pkg::VXEG_SEL_VIRT;
    end else begin
      romSel = vxeg_pkg::VXEG_SEL_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dma_r <= 1'b0;
      cdone_r <= 1'b0;
      crsv_r <= 1'b0;
    end else begin
      dma_r <= dma_nxt; // see (RULE12)
      cdone_r <= cdone_nxt;
      crsv_r <= crsv_nxt;
    end
  end

  assign dmaBlock = dma_r;
  assign cpuidDone = cdone_r;
  assign cpuidReserved = crsv_r;

  vxeg_cpuid_rom #(
    .AVAIL_CAP(AVAIL_CAP),
    .SECINIT_CAP(SECINIT_CAP),
    .LOCK_CAP(LOCK_CAP)
  ) romInst (
    .mclk(mclk),
    .rst(rst),
    .rdEn(cpuidValid),
    .sel(romSel),
    .data_r(cpuidData)
  );

  always_comb begin
    events = '0;
    events[`VXEG_EV_UD] = ud_r;
    events[`VXEG_EV_GP] = gp_r;
    events[`VXEG_EV_EXIT] = exit_r;
    events[`VXEG_EV_DMA] = dma_r;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_ud_no_enable: assert property (instrValid && needsEnable(instrOp) && !enable_r |=> udFault && !execOk) // see (RULE1)
    else $error("virt instruction ran with enable clear");
  a_secinit_gate: assert property (instrValid && enableOrSecinit(instrOp) && !enable_r && !SECINIT_CAP |=> udFault) // see (RULE2)
    else $error("secure-init class not refused");
  a_hv_bit_zero: assert property (cpuidDone && !cpuidReserved |-> !cpuidData[`VXEG_HV_PRESENT]) // see (RULE6)
    else $error("hypervisor-present bit set");
  a_rsv_leaf_zero: assert property (cpuidValid && cpuidLeaf[31:8] == 24'h40_0000 |=> cpuidReserved && cpuidData == 32'h0000_0000) // see (RULE7)
    else $error("reserved leaf returned data");
  a_guest_entry: assert property ($rose(inGuest) |-> $past(instrValid) && $past(instrOp) == vxeg_pkg::VXEG_OP_GUEST_ENTER && execOk) // see (RULE8)
    else $error("guest mode entered without guest-enter");
  a_intr_exit: assert property (inGuest && physIntrPend && intrExitEn |=> vmExit ##1 !inGuest) // see (RULE9)
    else $error("interrupt did not exit guest");
  a_virt_copy: assert property (inGuest && virtIntrEn |=> effIf == $past(virtIf) && effTpr == $past(virtTpr)) // see (RULE10)
    else $error("guest used physical mask copy");
  a_task_restart: assert property (inGuest && interceptTaskSwitch |=> vmExit && !restartOk) // see (RULE11)
    else $error("task switch marked restartable");
  a_dma_foreign: assert property (dmaValid && dmaPageOwner != dmaDevGuest |=> dmaBlock) // see (RULE12)
    else $error("foreign DMA not blocked");
  a_gp_priv: assert property (gpFault |-> gpErrCode == 16'h0000 && $past(curPriv) != 2'b00 && $past(enable_r)) // see (RULE13)
    else $error("protection fault with wrong cause");
  a_enable_next: assert property (busWr && busAddr == `VXEG_REG_CTRL && busWdata[0] && !disable_nxt ##1 instrValid && instrOp == vxeg_pkg::VXEG_OP_HV_CALL |=> !udFault) // see (RULE14)
    else $error("enable write missed next instruction");

  c_enter: cover property (instrValid && instrOp == vxeg_pkg::VXEG_OP_GUEST_ENTER ##1 $rose(inGuest));
  c_intr_exit: cover property (inGuest ##1 vmExit ##1 !inGuest);
  c_ud: cover property (udFault);
  c_irq: cover property ($rose(irq));

endmodule

/* tb/vxeg_sw_model.sv */
// software-side model: identification queries and the enable probe
// assumes the gate's identification port on mclk, one query at a time
`timescale 1ns/1ps
`include "vxeg_defs.svh"

module vxeg_sw_model (
  input wire logic mclk,
  input wire logic qryReq,
  input wire logic [31:0] qryLeaf,
  input wire logic probeReq,
  input wire logic disBit,
  input wire logic cpuidDone,
  input wire logic cpuidReserved,
  input wire logic [31:0] cpuidData,
  output logic cpuidValid,
  output logic [31:0] cpuidLeaf,
  output logic [31:0] ansData,
  output logic ansRsv,
  output logic [1:0] verdict,
  output logic swDone
);
  // released leaf shows the inverse, so a stale value never looks valid
  task automatic ask(input logic [31:0] lf);
    int n;
    @(posedge mclk);
    cpuidValid <= 1'h1;
    cpuidLeaf <= lf;
    @(posedge mclk);
    cpuidValid <= 1'h0;
    cpuidLeaf <= ~lf;
    n = 0;
    #1;
    while (cpuidDone !== 1'h1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    ansData = cpuidData;
    ansRsv = cpuidReserved;
  endtask

  // verdict: 0 absent, 1 allowed, 2 firmware-locked, 3 unlockable with key
  initial begin
    cpuidValid = 1'h0;
    cpuidLeaf = 32'h0000_0000;
    ansData = 32'h0000_0000;
    ansRsv = 1'h0;
    verdict = 2'h0;
    swDone = 1'h0;
    forever begin
      @(posedge mclk);
      if (probeReq === 1'h1 || qryReq === 1'h1) begin
        if (probeReq === 1'h1) begin
          ask(`VXEG_LEAF_EXT);
          if (ansData[`VXEG_CAP_AVAIL] !== 1'h1) begin
            verdict = 2'h0;
          end else if (disBit === 1'h0) begin
            verdict = 2'h1;
          end else begin
            ask(`VXEG_LEAF_VIRT);
            verdict = ansData[`VXEG_CAP_LOCKCAP] ? 2'h3 : 2'h2;
          end
        end else begin
          ask(qryLeaf);
        end
        @(posedge mclk);
        swDone <= 1'h1;
        @(posedge mclk);
        swDone <= 1'h0;
      end
    end
  end
endmodule

/* tb/tb_vxeg_gate.sv */
// self-checking bench of the virtualization enable gate
// assumes gate, package, defs header and vxeg_sw_model are compiled first
`timescale 1ns/1ps
`include "vxeg_defs.svh"

module tb_vxeg_gate;
  localparam logic SECINIT = 1'h0;
  logic mclk, rst, busWr, busRd, irq, instrValid, protMode, guestIntercept, interceptTaskSwitch;
  logic guestExit, intrExitEn, physIntrPend, virtIntrEn, physIf, virtIf, effIf, dmaValid;
  logic decValid, execOk, udFault, gpFault, inGuest, vmExit, restartOk, dmaBlock;
  logic cpuidValid, cpuidDone, cpuidReserved, qryReq, probeReq, disBit, ansRsv, swDone;
  logic [1:0] curPriv, verdict;
  logic [3:0] physTpr, virtTpr, effTpr, dmaDevGuest, dmaPageOwner;
  logic [7:0] busAddr;
  logic [15:0] gpErrCode;
  logic [31:0] busWdata, busRdata, cpuidLeaf, cpuidData, qryLeaf, ansData;
  vxeg_pkg::vxeg_op_t instrOp;
  int nFail, nTests;

  vxeg_gate #(.SECINIT_CAP(SECINIT)) vxeg_gate_i (.mclk, .rst, .busAddr, .busWdata, .busWr,
    .busRd, .busRdata, .irq, .instrValid, .instrOp, .curPriv, .protMode, .guestIntercept,
    .interceptTaskSwitch, .guestExit, .intrExitEn, .physIntrPend, .virtIntrEn, .physIf,
    .virtIf, .physTpr, .virtTpr, .dmaValid, .dmaDevGuest, .dmaPageOwner, .cpuidValid,
    .cpuidLeaf, .decValid, .execOk, .udFault, .gpFault, .gpErrCode, .inGuest, .vmExit,
    .restartOk, .effIf, .effTpr, .dmaBlock, .cpuidDone, .cpuidReserved, .cpuidData);
  vxeg_sw_model vxeg_sw_model_i (.mclk, .qryReq, .qryLeaf, .probeReq, .disBit, .cpuidDone,
    .cpuidReserved, .cpuidData, .cpuidValid, .cpuidLeaf, .ansData, .ansRsv, .verdict, .swDone);

  initial mclk = 1'h0;
  always #12.5 mclk = ~mclk;

  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finishTest();
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one-hot {gp, ud, exec} from the decode inputs
  function automatic logic [2:0] expDec(input vxeg_pkg::vxeg_op_t o, input logic en,
                                        input logic pm, input logic [1:0] pl);
    if (o == vxeg_pkg::VXEG_OP_GUEST_ENTER) begin
      return (!en || !pm) ? 3'h2 : (pl != 2'h0) ? 3'h4 : 3'h1;
    end
    if (o == vxeg_pkg::VXEG_OP_GI_SET || o == vxeg_pkg::VXEG_OP_SECURE_INIT) begin
      return (en || SECINIT) ? 3'h1 : 3'h2;
    end
    return en ? 3'h1 : 3'h2;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'h1;
    @(posedge mclk);
    busWr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge mclk);
    busAddr <= a;
    busRd <= 1'h1;
    @(posedge mclk);
    busRd <= 1'h0;
    #1;
    chk("busRdata", e, busRdata & m);
  endtask

  task automatic chkDec(input logic [2:0] e);
    chk("decode", {1'h1, e}, {decValid, gpFault, udFault, execOk});
    if (e == 3'h4) chk("gpErrCode", 32'h0000_0000, gpErrCode);
  endtask

  // back-to-back pair; also ends a write strobe raised with the first
  task automatic ins2(input vxeg_pkg::vxeg_op_t o1, input logic [2:0] e1,
                      input vxeg_pkg::vxeg_op_t o2, input logic [2:0] e2);
    instrValid <= 1'h1;
    instrOp <= o1;
    @(posedge mclk);
    instrOp <= o2;
    busWr <= 1'h0;
    #1 chkDec(e1);
    @(posedge mclk);
    instrValid <= 1'h0;
    #1 chkDec(e2);
  endtask

  // zero expectation means intercepted: caller checks the exit
  task automatic ins1(input vxeg_pkg::vxeg_op_t o, input logic [2:0] e);
    @(posedge mclk);
    instrValid <= 1'h1;
    instrOp <= o;
    @(posedge mclk);
    instrValid <= 1'h0;
    #1;
    if (e != 3'h0) chkDec(e);
  endtask

  task automatic waitExit(input logic rs);
    int n;
    n = 0;
    while (vmExit !== 1'h1 && n < 4) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("vmExit", 32'h1, vmExit);
    chk("restartOk", rs, restartOk);
    @(posedge mclk);
    #1 chk("inGuest", 32'h0, inGuest);
  endtask

  // one-cycle pulse: task-switch intercept when ts, else guest exit
  task automatic pulse(input logic ts);
    @(posedge mclk);
    if (ts) begin
      interceptTaskSwitch <= 1'h1;
    end else begin
      guestExit <= 1'h1;
    end
    @(posedge mclk);
    {interceptTaskSwitch, guestExit} <= 2'h0;
  endtask

  task automatic sw(input logic p, input logic [31:0] lf, input logic dis);
    int n;
    @(posedge mclk);
    probeReq <= p;
    qryReq <= !p;
    qryLeaf <= lf;
    disBit <= dis;
    @(posedge mclk);
    probeReq <= 1'h0;
    qryReq <= 1'h0;
    n = 0;
    while (swDone !== 1'h1 && n < 20) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("swDone", 32'h1, swDone);
  endtask

  initial begin
    #(25 * 8000);
    nFail++;
    finishTest();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic en, pm;
    logic [1:0] pl;
    logic [3:0] dv, pg;
    logic [31:0] lf;
    vxeg_pkg::vxeg_op_t o1, o2;
    {busWr, busRd, instrValid, protMode, guestIntercept, interceptTaskSwitch, guestExit} = '0;
    {intrExitEn, physIntrPend, virtIntrEn, physIf, virtIf, dmaValid, qryReq, probeReq} = '0;
    {busAddr, busWdata, curPriv, physTpr, virtTpr, dmaDevGuest, dmaPageOwner, qryLeaf} = '0;
    {disBit, nFail, nTests} = '0;
    instrOp = vxeg_pkg::VXEG_OP_NONE;
    void'($urandom(98));
    rst = 1'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    rd(`VXEG_REG_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`VXEG_REG_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`VXEG_REG_MODE, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(`VXEG_REG_CAP, 32'hFFFF_FFFF);
    rd(`VXEG_REG_CAP, 32'h0000_000C, 32'h0000_100C);
    @(posedge mclk);
    #1 chk("rdIdle", 32'h0000_0000, busRdata);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, 32'hFFFF_FFFF);
    @(posedge mclk);
    busAddr <= `VXEG_REG_CTRL;
    busWdata <= 32'h0000_0001;
    busWr <= 1'h1;
    ins2(vxeg_pkg::VXEG_OP_GI_CLEAR, 3'h2, vxeg_pkg::VXEG_OP_HV_CALL, 3'h1);
    for (int k = 0; k < 40; k++) begin
      en = 1'($urandom);
      pm = 1'($urandom);
      pl = 2'($urandom);
      o1 = vxeg_pkg::vxeg_op_t'(4'($urandom_range(8, 2)));
      o2 = vxeg_pkg::vxeg_op_t'(4'($urandom_range(8, 1)));
      wr(`VXEG_REG_CTRL, {31'h0000_0000, en});
      @(posedge mclk);
      protMode <= pm;
      curPriv <= pl;
      @(posedge mclk);
      ins2(o1, expDec(o1, en, pm, pl), o2, expDec(o2, en, pm, pl));
      if (inGuest === 1'h1) pulse(1'h0);
    end
    // guest entry, intercepts and interrupt exits
    wr(`VXEG_REG_CTRL, 32'h0000_0001);
    @(posedge mclk);
    protMode <= 1'h1;
    curPriv <= 2'h3;
    guestIntercept <= 1'h1;
    ins1(vxeg_pkg::VXEG_OP_GUEST_ENTER, 3'h4);
    @(posedge mclk);
    curPriv <= 2'h0;
    ins1(vxeg_pkg::VXEG_OP_GUEST_ENTER, 3'h1);
    rd(`VXEG_REG_MODE, 32'h0000_0001, 32'h0000_0001);
    ins1(vxeg_pkg::VXEG_OP_STATE_SAVE, 3'h0);
    waitExit(1'h1);
    ins1(vxeg_pkg::VXEG_OP_GUEST_ENTER, 3'h1);
    pulse(1'h1);
    #1 waitExit(1'h0);
    ins1(vxeg_pkg::VXEG_OP_GUEST_ENTER, 3'h1);
    @(posedge mclk);
    physIntrPend <= 1'h1;
    repeat (4) @(posedge mclk);
    #1 chk("inGuest", 32'h1, inGuest);
    @(posedge mclk);
    intrExitEn <= 1'h1;
    #1 waitExit(1'h1);
    @(posedge mclk);
    {physIntrPend, intrExitEn} <= 2'h0;
    ins1(vxeg_pkg::VXEG_OP_GUEST_ENTER, 3'h1);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      virtIntrEn <= k[0];
      {physIf, virtIf, physTpr, virtTpr} <= 10'($urandom);
      @(posedge mclk);
      #1 chk("effIf", virtIntrEn ? virtIf : physIf, effIf);
      chk("effTpr", virtIntrEn ? virtTpr : physTpr, effTpr);
    end
    pulse(1'h0);
    // device accesses against page owners, same-owner pairs first
    for (int k = 0; k < 24; k++) begin
      dv = 4'($urandom_range(15, 1));
      pg = (k < 2) ? dv : (k < 4) ? 4'h0 : 4'($urandom);
      @(posedge mclk);
      dmaValid <= 1'h1;
      dmaDevGuest <= dv;
      dmaPageOwner <= pg;
      @(posedge mclk);
      dmaValid <= 1'h0;
      #1 chk("dmaBlock", (pg == 4'h0 || pg != dv), dmaBlock);
    end
    // identification words through the software model
    sw(1'h0, `VXEG_LEAF_BASIC, 1'h0);
    chk("hvPresent", 32'h0, ansData[`VXEG_HV_PRESENT]);
    sw(1'h0, `VXEG_LEAF_EXT, 1'h0);
    chk("extFlags", {SECINIT, 12'h004}, ansData[12:0]);
    for (int k = 0; k < 5; k++) begin
      lf = (k == 0) ? `VXEG_LEAF_HV_LO : (k == 1) ? `VXEG_LEAF_HV_HI : (k == 3) ?
           `VXEG_LEAF_HV_HI + 32'h1 : (k == 4) ? `VXEG_LEAF_HV_LO - 32'h1 :
           `VXEG_LEAF_HV_LO + 32'($urandom_range(254, 1));
      sw(1'h0, lf, 1'h0);
      chk("hvLeafData", 32'h0000_0000, ansData);
      chk("hvLeafFlag", (k < 3), ansRsv);
    end
    // interrupt: raise, clear, mask
    wr(`VXEG_REG_STAT, 32'h0000_000F);
    wr(`VXEG_REG_MASK, 32'h0000_0001);
    wr(`VXEG_REG_CTRL, 32'h0000_0000);
    ins1(vxeg_pkg::VXEG_OP_STATE_LOAD, 3'h2);
    @(posedge mclk);
    #1 chk("irq", 32'h1, irq);
    rd(`VXEG_REG_STAT, 32'h0000_0001, 32'hFFFF_FFFF);
    wr(`VXEG_REG_STAT, 32'h0000_0001);
    @(posedge mclk);
    #1 chk("irq", 32'h0, irq);
    ins1(vxeg_pkg::VXEG_OP_HV_CALL, 3'h2);
    wr(`VXEG_REG_MASK, 32'h0000_0000);
    @(posedge mclk);
    #1 chk("irqMasked", 32'h0, irq);
    rd(`VXEG_REG_STAT, 32'h0000_0001, 32'hFFFF_FFFF);
    // enable probe before and after the disable bit
    sw(1'h1, 32'h0000_0000, 1'h0);
    chk("verdict", 32'h1, verdict);
    wr(`VXEG_REG_CTRL, 32'h0000_0002);
    wr(`VXEG_REG_CTRL, 32'h0000_0003);
    rd(`VXEG_REG_CTRL, 32'h0000_0002, 32'h0000_0003);
    ins1(vxeg_pkg::VXEG_OP_PAGE_INV, 3'h2);
    sw(1'h1, 32'h0000_0000, 1'h1);
    chk("verdict", 32'h3, verdict);
    // once locked, a write cannot take the disable bit back
    wr(`VXEG_REG_CTRL, 32'h0000_0006);
    wr(`VXEG_REG_CTRL, 32'h0000_0001);
    rd(`VXEG_REG_CTRL, 32'h0000_0006, 32'h0000_0007);
    finishTest();
  end
endmodule
